// >>> acc_correct.sv
// digital offset and full-scale correction of the sigma-delta result
// assumes raw results arrive as a one-cycle valid with data, synchronous to clk_sys
`timescale 1ns/100ps
`default_nettype none
module acc_correct #(
  parameter int DATA_W = 24
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire acc_pkg::acc_sample_t raw_in,
  input  wire acc_pkg::acc_coding_t coding,
  input  wire logic [2:0]          amplifier_gain_setting,
  input  wire logic                zero_cal_en,
  input  wire logic                ofs_wr_en,
  input  wire logic [DATA_W-1:0]   ofs_wr_data,
  input  wire logic                fs_wr_en,
  input  wire logic [DATA_W-1:0]   fs_wr_data,
  output acc_pkg::acc_sample_t     data_out,
  output logic [DATA_W-1:0]        ofs_coef,
  output logic [DATA_W-1:0]        fs_coef,
  output logic                     zero_cal_done,
  output logic [2:0]               gain_seen
);
  localparam int DIFF_W = DATA_W + 2;
  localparam int PROD_W = DIFF_W + DATA_W + 1;
  localparam int SUM_W  = PROD_W + 1;

  logic [DATA_W-1:0]        ofs_q;
  logic [DATA_W-1:0]        fs_q;
  logic [DATA_W-1:0]        ofs_use_q;
  logic signed [DIFF_W-1:0] raw_ext;
  logic signed [DIFF_W-1:0] ofs_rel;
  logic signed [DIFF_W-1:0] diff_d;
  logic signed [DIFF_W-1:0] diff_q;
  logic signed [DIFF_W-1:0] cal_sum;
  logic                     v1_q;
  logic                     v2_q;
  logic                     zc1_q;
  logic                     zc2_q;
  logic                     bip1_q;
  logic                     bip2_q;
  logic signed [PROD_W-1:0] prod_d;
  logic signed [PROD_W-1:0] prod_q;
  logic signed [SUM_W-1:0]  uni_d;
  logic signed [SUM_W-1:0]  bip_d;
  logic signed [SUM_W-1:0]  sum_d;
  logic [DATA_W-1:0]        sat_d;
  logic                     out_v_d;
  logic                     zdone_d;
  acc_pkg::acc_sample_t     data_q;
  logic                     zdone_q;
  logic [2:0]               gain_q;

  // raw is unsigned in 2^23 units; two guard bits hold the signed difference
  always_comb begin
    raw_ext = $signed({2'b00, raw_in.value});
    ofs_rel = $signed({2'b00, ofs_q}) - $signed({2'b00, acc_pkg::ACC_OFS_BIAS});
  end

  // offset removed in front of the multiplier
  always_comb begin
    diff_d = raw_ext - ofs_rel;
  end

  // diff plus the offset it used is raw plus bias, so the zero point maps to zero
  always_comb begin
    cal_sum = diff_q + $signed({2'b00, ofs_use_q});
  end

  // coefficient storage; nominal values after reset
  // a calibration load wins over a host write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ofs_q <= acc_pkg::ACC_OFS_NOM;
    end else if (zc1_q && v1_q) begin
      ofs_q <= cal_sum[DATA_W-1:0];
    end else if (ofs_wr_en) begin
      ofs_q <= ofs_wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fs_q <= acc_pkg::ACC_FS_NOM;
    end else if (fs_wr_en) begin
      fs_q <= fs_wr_data;
    end
  end

  // stage 1: difference, and the offset it was formed with
  // keeping that offset stops a host write in the same cycle as a calibration sample skewing the load
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      diff_q    <= '0;
      ofs_use_q <= acc_pkg::ACC_OFS_NOM;
    end else begin
      diff_q    <= diff_d;
      ofs_use_q <= ofs_q;
    end
  end

  // stage 1 control: valid, calibration flag and coding travel with the sample
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      v1_q   <= 1'b0;
      zc1_q  <= 1'b0;
      bip1_q <= 1'b0;
    end else begin
      v1_q   <= raw_in.valid;
      zc1_q  <= zero_cal_en;
      bip1_q <= (coding == acc_pkg::ACC_CODE_BIPOLAR);
    end
  end

  // pure multiply by fs; the divide by 0x400000 is a shift further on
  // operands widened first so the product is never cut to an operand width
  always_comb begin
    prod_d = PROD_W'(diff_q) * PROD_W'($signed({1'b0, fs_q}));
  end

  // stage 2: the coefficient is used live, so a write mid-sample affects that sample and every later one
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prod_q <= '0;
    end else begin
      prod_q <= prod_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      v2_q   <= 1'b0;
      zc2_q  <= 1'b0;
      bip2_q <= 1'b0;
    end else begin
      v2_q   <= v1_q;
      zc2_q  <= zc1_q;
      bip2_q <= bip1_q;
    end
  end

  // unipolar doubles, so it shifts one place less
  always_comb begin
    uni_d = SUM_W'(prod_q >>> (acc_pkg::ACC_FS_SHIFT - 1));
  end

  // bipolar adds midscale so a zero input sits mid-range
  always_comb begin
    bip_d = SUM_W'(prod_q >>> acc_pkg::ACC_FS_SHIFT)
          + $signed({{(SUM_W-DATA_W){1'b0}}, acc_pkg::ACC_MIDSCALE});
  end

  always_comb begin
    if (bip2_q) begin
      sum_d = bip_d;
    end else begin
      sum_d = uni_d;
    end
  end

  // clamp instead of wrap, so an overdriven input never folds to the other end
  acc_saturate #(
    .IN_W  (SUM_W),
    .OUT_W (DATA_W)
  ) acc_saturate_i (
    .din  (sum_d),
    .dout (sat_d)
  );

  // calibration samples are not presented as data
  always_comb begin
    out_v_d = v2_q && !zc2_q;
    zdone_d = zc1_q && v1_q;
  end

  // stage 3: output word
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_q <= '0;
    end else begin
      data_q.valid <= out_v_d;
      data_q.value <= sat_d;
    end
  end

  // done pulses in the cycle the new offset appears
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      zdone_q <= 1'b0;
    end else begin
      zdone_q <= zdone_d;
    end
  end

  // the gain setting does not enter the math: the front end applies it ahead of conversion
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gain_q <= '0;
    end else begin
      gain_q <= amplifier_gain_setting;
    end
  end

  assign data_out      = data_q;
  assign ofs_coef      = ofs_q;
  assign fs_coef       = fs_q;
  assign zero_cal_done = zdone_q;
  assign gain_seen     = gain_q;
endmodule
`default_nettype wire

// >>> acc_correct_sva.sv
// checker for the calibration correction datapath
// assumes it is bound to acc_correct at its default width
`timescale 1ns/100ps
`default_nettype none
module acc_chk (
  input wire logic                 clk_sys,
  input wire logic                 rst,
  input wire acc_pkg::acc_sample_t raw_in,
  input wire acc_pkg::acc_coding_t coding,
  input wire logic                 zero_cal_en,
  input wire logic                 ofs_wr_en,
  input wire logic [23:0]          ofs_wr_data,
  input wire acc_pkg::acc_sample_t data_out,
  input wire logic [23:0]          ofs_coef,
  input wire logic [23:0]          fs_coef,
  input wire logic                 zero_cal_done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic sm = raw_in.valid && !zero_cal_en;
  wire logic cs = raw_in.valid && zero_cal_en;
  // offset cancels the sample exactly, so the output is pinned
  wire logic zp = sm && ({1'b0, raw_in.value} + {1'b0, acc_pkg::ACC_OFS_BIAS}) == {1'b0, ofs_coef};
  a_out_latency: assert property (sm |-> ##3 data_out.valid)
    else $error("sample gave no output");
  a_cal_quiet: assert property (cs |-> ##3 !data_out.valid)
    else $error("calibration sample gave output");
  a_cal_done: assert property (cs |-> ##2 zero_cal_done)
    else $error("calibration done missing");
  a_cal_load: assert property (cs |-> ##2
    ofs_coef == $past(raw_in.value, 2) + acc_pkg::ACC_OFS_BIAS)
    else $error("calibration offset wrong");
  a_ofs_write: assert property (ofs_wr_en && !$past(cs) |=> ofs_coef == $past(ofs_wr_data))
    else $error("offset write lost");
  a_coef_reset: assert property ($fell(rst) |-> ofs_coef == acc_pkg::ACC_OFS_NOM &&
    fs_coef == acc_pkg::ACC_FS_NOM) else $error("coefficients not nominal");
  a_bip_mid: assert property (zp && coding == acc_pkg::ACC_CODE_BIPOLAR |->
    ##3 data_out.value == acc_pkg::ACC_MIDSCALE) else $error("bipolar zero off midscale");
  a_uni_zero: assert property (zp && coding == acc_pkg::ACC_CODE_UNIPOLAR |->
    ##3 data_out.value == 24'h000000) else $error("unipolar zero not zero");
  cover property (cs ##2 zero_cal_done);
  cover property (zp ##3 data_out.valid);
  cover property (ofs_wr_en);
endmodule
`default_nettype wire

// >>> acc_pkg.sv
// package for the calibration correction datapath: widths, nominal coefficients, types
// assumes a 24-bit converter core feeding a raw attenuated result in 2^23 units
package acc_pkg;
  localparam int          ACC_W          = 24;
  localparam logic [23:0] ACC_OFS_NOM    = 24'h800000;
  localparam logic [23:0] ACC_FS_NOM     = 24'h555555;
  localparam logic [23:0] ACC_OFS_BIAS   = 24'h800000;
  localparam logic [23:0] ACC_MIDSCALE   = 24'h800000;
  localparam int          ACC_FS_SHIFT   = 22;
  localparam int          ACC_PIPE_LAT   = 3;

  typedef enum logic {
    ACC_CODE_UNIPOLAR,
    ACC_CODE_BIPOLAR
  } acc_coding_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] value;
  } acc_sample_t;
endpackage

// >>> acc_saturate.sv
// saturating narrow stage: clamps a signed wide value to the unsigned output range
// assumes the caller registers the result
`timescale 1ns/100ps
`default_nettype none
module acc_saturate #(
  parameter int IN_W  = 50,
  parameter int OUT_W = 24
) (
  input  wire logic signed [IN_W-1:0] din,
  output logic             [OUT_W-1:0] dout
);
  localparam logic signed [IN_W-1:0] MAX_V = (IN_W'(1) <<< OUT_W) - IN_W'(1);

  always_comb begin
    if (din < 0) begin
      dout = '0;
    end else if (din > MAX_V) begin
      dout = '1;
    end else begin
      dout = din[OUT_W-1:0];
    end
  end
endmodule
`default_nettype wire

// >>> tb_adc_calibration_correction.sv
// testbench for the calibration correction datapath
// assumes acc_pkg, acc_correct and acc_chk are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_adc_calibration_correction;
  logic clk_sys = 1'b0, rst = 1'b1, zero_cal_en = 1'b0, ofs_wr_en = 1'b0, fs_wr_en = 1'b0;
  logic [23:0] ofs_wr_data = 24'h000000, fs_wr_data = 24'h000000, ofs_coef, fs_coef;
  logic [23:0] eo = acc_pkg::ACC_OFS_NOM, ef = acc_pkg::ACC_FS_NOM;
  logic [23:0] vals[4] = '{24'h000000, 24'h300000, 24'h600000, 24'hFFFFFF};
  logic [2:0] amplifier_gain_setting = 3'h5, gain_seen;
  acc_pkg::acc_sample_t raw_in = '0, data_out;
  acc_pkg::acc_coding_t coding = acc_pkg::ACC_CODE_UNIPOLAR;
  logic zero_cal_done;
  int bad_count = 0, samples_checked = 0, cycles = 0;
  initial forever #2.5 clk_sys = ~clk_sys;
  acc_correct acc_correct_i (.clk_sys, .rst, .raw_in, .coding, .amplifier_gain_setting,
    .zero_cal_en, .ofs_wr_en, .ofs_wr_data, .fs_wr_en, .fs_wr_data, .data_out, .ofs_coef,
    .fs_coef, .zero_cal_done, .gain_seen);
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic cmp(input logic [23:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // floor shifts and clamping keep overflow from wrapping
  function automatic logic [23:0] model(logic [23:0] r, o, f, logic b);
    longint p;
    p = (longint'(r) - longint'(o) + 64'sh800000) * longint'(f);
    p = b ? (p >>> 22) + 64'sh800000 : p >>> 21;
    return p < 0 ? 24'h000000 : p > 64'shFFFFFF ? 24'hFFFFFF : p[23:0];
  endfunction
  task automatic smp(logic [23:0] r, logic b);
    raw_in = '{1'b1, r};
    coding = acc_pkg::acc_coding_t'(b);
    tick(1);
    raw_in.valid = 1'b0;
    tick(2);
    cmp(data_out.value, model(r, eo, ef, b));
    cmp({23'h000000, data_out.valid}, 24'h000001);
  endtask
  task automatic wr(logic [23:0] o, f);
    {ofs_wr_en, fs_wr_en, ofs_wr_data, fs_wr_data, eo, ef} = {2'h3, o, f, o, f};
    tick(1);
    {ofs_wr_en, fs_wr_en} = 2'h0;
    cmp(ofs_coef, o);
    cmp(fs_coef, f);
  endtask
  task automatic t_nominal;
    cmp(ofs_coef, acc_pkg::ACC_OFS_NOM);
    cmp(fs_coef, acc_pkg::ACC_FS_NOM);
    cmp({21'h000000, gain_seen}, 24'h000000);
    foreach (vals[i]) for (int b = 0; b < 2; b++) smp(vals[i], b[0]);
    cmp({21'h000000, gain_seen}, 24'h000005);
  endtask
  task automatic t_coefs;
    wr(24'h900000, 24'h2AAAAA);
    for (int b = 0; b < 2; b++) smp(24'h000000, b[0]);
    smp(24'hA00000, 1'b0);
    wr(24'h7F0000, 24'h600000);
    for (int b = 0; b < 2; b++) smp(24'h400000, b[0]);
  endtask
  // the zero point must read back as zero, so the offset is the point plus the bias
  task automatic t_cal(logic [23:0] r);
    {zero_cal_en, raw_in} = {1'b1, 1'b1, r};
    tick(1);
    {zero_cal_en, raw_in.valid, ofs_wr_en, ofs_wr_data} = {3'h1, 24'h111111};
    tick(1);
    ofs_wr_en = 1'b0;
    eo = r + acc_pkg::ACC_OFS_BIAS;
    cmp({23'h000000, zero_cal_done}, 24'h000001);
    cmp(ofs_coef, eo);
    tick(1);
    cmp({23'h000000, data_out.valid}, 24'h000000);
    cmp({23'h000000, zero_cal_done}, 24'h000000);
    cmp(ofs_coef, eo);
    for (int b = 0; b < 2; b++) smp(r, b[0]);
  endtask
  task automatic t_gain;
    amplifier_gain_setting = 3'h2;
    tick(1);
    cmp({21'h000000, gain_seen}, 24'h000002);
    t_cal(24'h0A0000);
  endtask
  task automatic t_reset;
    wr(24'h812345, 24'h700000);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    {eo, ef} = {acc_pkg::ACC_OFS_NOM, acc_pkg::ACC_FS_NOM};
    cmp(ofs_coef, eo);
    cmp(fs_coef, ef);
    cmp({21'h000000, gain_seen}, 24'h000000);
    cmp({23'h000000, data_out.valid}, 24'h000000);
    smp(24'h600000, 1'b1);
  endtask
  task automatic t_host_ofs;
    longint stp;
    smp(24'h030000, 1'b1);
    // one offset step weighs fs/0x400000 data steps, so the host divides by that ratio
    stp = ((longint'(data_out.value) - 64'sh800000) * 64'sh400000) / longint'(ef);
    wr(24'(64'sh800000 + stp), ef);
    smp(24'h030000, 1'b1);
    cmp({23'h000000, data_out.value - acc_pkg::ACC_MIDSCALE < 24'h000003}, 24'h000001);
  endtask
  task automatic conclude;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    tick(10);
    rst = 1'b0;
    t_nominal();
    t_coefs();
    t_cal(24'h123456); // zero-scale is calibrated
    t_cal(24'h0F0000);
    t_gain();
    t_reset();
    t_host_ofs();
    conclude();
  end
endmodule
bind acc_correct acc_chk acc_chk_i (.clk_sys, .rst, .raw_in, .coding, .zero_cal_en,
  .ofs_wr_en, .ofs_wr_data, .data_out, .ofs_coef, .fs_coef, .zero_cal_done);
`default_nettype wire
